// File: logic/sgp_shared_irq.sv
`timescale 1ns/1ns
// Contract
// - shared irq has group, trigger mode, route
// - extended range 4096-5119, off in legacy
// - message capability bit; secure, non-secure registers
// - edge: message set pends; activation, clears remove
// - level: message set pends until message clear
// - level acked while asserted: active and pending
// - level cross-clear behaviour fixed and documented
// - ack clearing software pending is fixed choice
// - security on: three groups, group 0 secure
// - security off: one state, two groups
// - group from select bit plus modifier bit
// - locality irqs non-secure group 1 or group 1
// - per group ack, completion, point, highest, enable
// - common point bit reuses group 0 point
// - separate common point selects per security state
// - security on: requester state checked
// - security off: no requester state checks
// - sgi raise depends state and access control
// - security off: sgi raised regardless of control
// - secure group 1 as group 0 conditions
// - active and pending never signalled
// - ack read moves pending to active
module sgp_shared_irq
    import sgp_pkg::*;
(
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_SECURE,
    output logic [31:0] O_RDATA,
    // wired peripheral lines
    input wire logic [NIRQ-1:0] I_WIRED_IRQ,
    // toward the processor_element
    output logic O_IRQ_G0,
    output logic O_IRQ_G1,
    output logic O_SGI_RAISE,
    output logic [1:0] O_SGI_GRP
);
    // ******************************
    // state and helpers
    // ******************************
    sgp_state_t r; // registered state
    sgp_state_t next_r; // next state
    logic ds; // single security state
    logic legacy; // extended range disabled
    logic [NIRQ-1:0] impl_m; // implemented ids
    logic [NIRQ-1:0] acc_m; // requester may touch
    logic [NIRQ-1:0] pend_v; // pending, any source
    logic [NIRQ-1:0] cand0, cand1, cand1t; // signalable
    logic [1:0] dgrp [NIRQ]; // distributor group
    logic [1:0] cgrp [NIRQ]; // cpu interface view
    logic [1:0] tgt1; // group 1 seen by requester
    logic en1t; // its enable
    logic [IDX_W:0] wr_look; // valid flag and index
    logic [IDX_W-1:0] wr_idx; // index of named id
    logic [IDX_W-1:0] hp0, hp1; // highest pending
    logic hv0, hv1; // highest valid
    logic [NIRQ-1:0] set_m, mclr_m, pset_m, pclr_m, ack_m, deact_m;
    logic [NIRQ-1:0] clr_msg, clr_sw, wired_rise;
    logic ack0_ns; // non-secure group 0 ack

    // ******************************
    // identifier helpers
    // ******************************
    // map an id to an index; out-of-range ids come back invalid
    function automatic logic [IDX_W:0] id_lookup(
        input logic [ID_W-1:0] id,
        input logic leg
    );
        logic [IDX_W:0] res;
        res = '0;
        if (id >= BASE_ID && id < BASE_ID + ID_W'(NBASE))
        begin
            res = {1'b1, IDX_W'(id - BASE_ID)};
        end
        else if (HAS_ESPI && !leg && id >= EXT_ID && id <= EXT_LAST
                 && id < EXT_ID + ID_W'(NIRQ - NBASE))
        begin
            res = {1'b1, IDX_W'(id - EXT_ID + ID_W'(NBASE))};
        end
        return res;
    endfunction : id_lookup

    function automatic logic [ID_W-1:0] idx_id(input logic [IDX_W-1:0] i);
        logic [ID_W-1:0] res;
        res = (32'(i) < NBASE) ? BASE_ID + ID_W'(i)
                               : EXT_ID + ID_W'(i) - ID_W'(NBASE);
        return res;
    endfunction : idx_id

    // ******************************
    // next state
    // ******************************
    // one pass: decode the access, then update pending and active
    always_comb
    begin
        next_r = r;
        next_r.rdata = '0;
        next_r.software_generated_irq = 1'b0;
        ds = r.ctrl[C_DS];
        legacy = r.ctrl[C_LEGACY];
        impl_m = '0;
        acc_m = '0;
        cand0 = '0;
        cand1 = '0;
        cand1t = '0;
        set_m = '0;
        mclr_m = '0;
        pset_m = '0;
        pclr_m = '0;
        ack_m = '0;
        deact_m = '0;
        hp0 = '0;
        hp1 = '0;
        hv0 = 1'b0;
        hv1 = 1'b0;
        // single state: group 1 is one group, keyed as non-secure
        tgt1 = (ds || !I_SECURE) ? GRP_NS1 : GRP_S1;
        en1t = (tgt1 == GRP_S1) ? r.ctrl[C_EN1S] : r.ctrl[C_EN1NS];
        ack0_ns = !ds && !I_SECURE;
        wr_look = id_lookup(I_WDATA[ID_W-1:0], legacy);
        wr_idx = wr_look[IDX_W-1:0];
        // wired lines: a change counts once stages two and three agree
        next_r.s1 = I_WIRED_IRQ;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.filt = (r.s2 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
        wired_rise = next_r.filt & ~r.filt & r.edge_cfg;
        pend_v = r.pend_sw | r.pend_msg | (r.filt & ~r.edge_cfg);
        for (int i = 0; i < NIRQ; i++)
        begin
            impl_m[i] = (i < NBASE) || (HAS_ESPI && !legacy);
            if (ds)
            begin
                dgrp[i] = r.grp[i] ? GRP_NS1 : GRP_G0;
            end
            else if (r.grp[i])
            begin
                dgrp[i] = GRP_NS1;
            end
            else
            begin
                dgrp[i] = r.modf[i] ? GRP_S1 : GRP_G0;
            end
            // secure group 1 folds into group 0 without the top level
            cgrp[i] = dgrp[i];
            if (dgrp[i] == GRP_S1 && (!r.ctrl[C_EL3] || !r.ctrl[C_SRE]))
            begin
                cgrp[i] = GRP_G0;
            end
            // non-secure requester touches only non-secure group 1
            acc_m[i] = impl_m[i] && (ds || I_SECURE
                                     || dgrp[i] == GRP_NS1);
            // active and pending stays hidden from the element
            cand0[i] = pend_v[i] && !r.act[i] && cgrp[i] == GRP_G0
                       && r.ctrl[C_EN0];
            cand1[i] = pend_v[i] && !r.act[i]
                       && ((cgrp[i] == GRP_NS1 && r.ctrl[C_EN1NS])
                       || (cgrp[i] == GRP_S1 && r.ctrl[C_EN1S]));
            cand1t[i] = pend_v[i] && !r.act[i] && cgrp[i] == tgt1 && en1t;
        end
        // lowest index wins; no priority field is kept here
        for (int i = NIRQ - 1; i >= 0; i--)
        begin
            if (cand0[i])
            begin
                hp0 = IDX_W'(i);
                hv0 = 1'b1;
            end
            if (cand1t[i])
            begin
                hp1 = IDX_W'(i);
                hv1 = 1'b1;
            end
        end
        // register writes
        if (I_WR)
        begin
            if (I_ADDR == A_CTRL && (ds || I_SECURE))
            begin
                next_r.ctrl = I_WDATA[CTRL_W-1:0];
            end
            else if (I_ADDR == A_SET_NS && HAS_MBIS && wr_look[IDX_W])
            begin
                // non-secure view reaches non-secure group 1 only
                set_m[wr_idx] = ds || dgrp[wr_idx] == GRP_NS1;
            end
            else if (I_ADDR == A_SET_S && HAS_MBIS && wr_look[IDX_W])
            begin
                set_m[wr_idx] = ds || I_SECURE;
            end
            else if (I_ADDR == A_CLR_NS && HAS_MBIS && wr_look[IDX_W])
            begin
                mclr_m[wr_idx] = ds || dgrp[wr_idx] == GRP_NS1;
            end
            else if (I_ADDR == A_CLR_S && HAS_MBIS && wr_look[IDX_W])
            begin
                mclr_m[wr_idx] = ds || I_SECURE;
            end
            else if (I_ADDR == A_PSET)
            begin
                pset_m = I_WDATA[NIRQ-1:0] & acc_m;
            end
            else if (I_ADDR == A_PCLR)
            begin
                pclr_m = I_WDATA[NIRQ-1:0] & acc_m;
            end
            else if (I_ADDR == A_GRP && (ds || I_SECURE))
            begin
                next_r.grp = I_WDATA[NIRQ-1:0];
            end
            else if (I_ADDR == A_MOD && (ds || I_SECURE))
            begin
                next_r.modf = I_WDATA[NIRQ-1:0];
            end
            else if (I_ADDR == A_EDGE)
            begin
                next_r.edge_cfg = (r.edge_cfg & ~acc_m)
                                  | (I_WDATA[NIRQ-1:0] & acc_m);
            end
            else if (I_ADDR == A_ROUTE)
            begin
                next_r.route = (r.route & ~acc_m)
                               | (I_WDATA[NIRQ-1:0] & acc_m);
            end
            else if (I_ADDR == A_EOI0 && wr_look[IDX_W] && !ack0_ns)
            begin
                deact_m[wr_idx] = cgrp[wr_idx] == GRP_G0;
            end
            else if (I_ADDR == A_EOI1 && wr_look[IDX_W])
            begin
                deact_m[wr_idx] = cgrp[wr_idx] == tgt1;
            end
            else if (I_ADDR == A_BP0 && !ack0_ns)
            begin
                next_r.bp0 = I_WDATA[BPR_W-1:0];
            end
            else if (I_ADDR == A_BP1 && tgt1 == GRP_S1)
            begin
                next_r.bp1s = I_WDATA[BPR_W-1:0];
            end
            else if (I_ADDR == A_BP1)
            begin
                next_r.bp1ns = I_WDATA[BPR_W-1:0];
            end
            else if (I_ADDR == A_NSACR && (ds || I_SECURE))
            begin
                next_r.nsacr = I_WDATA[1:0];
            end
            else if (I_ADDR == A_SGI)
            begin
                // secure or single-state requesters always may raise
                next_r.software_generated_irq = ds || I_SECURE
                    || I_WDATA[1:0] == GRP_NS1
                    || (I_WDATA[1:0] == GRP_G0 && r.nsacr[NSACR_G0])
                    || (I_WDATA[1:0] == GRP_S1
                        && r.nsacr[NSACR_S1]);
                next_r.sgi_grp = I_WDATA[1:0];
            end
        end
        // register reads; the answer stands one cycle later
        if (I_RD)
        begin
            if (I_ADDR == A_CTRL)
            begin
                next_r.rdata = 32'(r.ctrl);
            end
            else if (I_ADDR == A_TYPE)
            begin
                next_r.rdata[T_ESPI] = HAS_ESPI && !legacy;
                next_r.rdata[T_MBIS] = HAS_MBIS;
                next_r.rdata[T_LPI+:2] = GRP_NS1;
            end
            else if (I_ADDR == A_PSET || I_ADDR == A_PCLR)
            begin
                next_r.rdata = 32'(pend_v & acc_m);
            end
            else if (I_ADDR == A_GRP)
            begin
                next_r.rdata = 32'(r.grp);
            end
            else if (I_ADDR == A_MOD)
            begin
                next_r.rdata = 32'(r.modf);
            end
            else if (I_ADDR == A_EDGE)
            begin
                next_r.rdata = 32'(r.edge_cfg);
            end
            else if (I_ADDR == A_ROUTE)
            begin
                next_r.rdata = 32'(r.route);
            end
            else if (I_ADDR == A_ACT)
            begin
                next_r.rdata = 32'(r.act & acc_m);
            end
            else if (I_ADDR == A_ACK0 || I_ADDR == A_HP0)
            begin
                next_r.rdata = 32'(SPURIOUS);
                if (hv0 && !ack0_ns)
                begin
                    next_r.rdata = 32'(idx_id(hp0));
                    ack_m[hp0] = I_ADDR == A_ACK0;
                end
            end
            else if (I_ADDR == A_ACK1 || I_ADDR == A_HP1)
            begin
                next_r.rdata = 32'(SPURIOUS);
                if (hv1)
                begin
                    next_r.rdata = 32'(idx_id(hp1));
                    ack_m[hp1] = I_ADDR == A_ACK1;
                end
            end
            else if (I_ADDR == A_BP0)
            begin
                next_r.rdata = 32'(r.bp0);
            end
            else if (I_ADDR == A_BP1)
            begin
                // global common bit first, then per-state selects
                if (r.ctrl[C_CBPR]
                    || (tgt1 == GRP_S1 && r.ctrl[C_CBPR_S])
                    || (tgt1 == GRP_NS1 && r.ctrl[C_CBPR_NS]))
                begin
                    next_r.rdata = 32'(r.bp0);
                end
                else
                begin
                    next_r.rdata = 32'((tgt1 == GRP_S1) ? r.bp1s : r.bp1ns);
                end
            end
            else if (I_ADDR == A_NSACR)
            begin
                next_r.rdata = 32'(r.nsacr);
            end
        end
        // edge: activation and every clear drop it; level: only msg clear
        clr_msg = (r.edge_cfg & (mclr_m | pclr_m | ack_m))
                  | (~r.edge_cfg & mclr_m)
                  | (~r.edge_cfg & pclr_m & {NIRQ{LVL_PCLR_MSG}});
        clr_sw = pclr_m | (r.edge_cfg & mclr_m)
                 | (~r.edge_cfg & mclr_m & {NIRQ{LVL_MCLR_SW}})
                 | (ack_m & {NIRQ{ACK_CLR_SW}});
        // a set in the same cycle as a clear wins
        next_r.pend_msg = (r.pend_msg & ~clr_msg) | set_m
                          | (wired_rise & impl_m);
        next_r.pend_sw = (r.pend_sw & ~clr_sw) | pset_m;
        // a level source still asserted stays pending: active and pending
        next_r.act = (r.act & ~(deact_m & r.act)) | ack_m;
        next_r.irq0 = |cand0;
        next_r.irq1 = |cand1;
    end

    // ******************************
    // state register
    // ******************************
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_RST)
        begin
            r <= SGP_STATE_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign O_RDATA = r.rdata;
    assign O_IRQ_G0 = r.irq0;
    assign O_IRQ_G1 = r.irq1;
    assign O_SGI_RAISE = r.software_generated_irq;
    assign O_SGI_GRP = r.sgi_grp;

    // ******************************
    // checks
    // ******************************
    hidden_ap_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        ((pend_v & ~r.act) == '0) |=> !O_IRQ_G0 && !O_IRQ_G1)
        else $error("active interrupt signalled");
    edge_set_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (set_m != '0 && r.edge_cfg[wr_idx]) |=> r.pend_msg[$past(wr_idx)])
        else $error("edge message set did not pend");
    level_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (mclr_m == '0 && !LVL_PCLR_MSG) |=>
        (($past(r.pend_msg & ~r.edge_cfg) & ~r.pend_msg) == '0))
        else $error("level message pend lost without clear");
    level_ack_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (ack_m != '0 && !r.edge_cfg[hp0] && r.pend_msg[hp0]
         && I_ADDR == A_ACK0 && mclr_m == '0) |=>
        r.act[$past(hp0)] && r.pend_msg[$past(hp0)])
        else $error("level ack not active and pending");
    ack_active_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_RD && I_ADDR == A_ACK1 && hv1) |=>
        r.act[$past(hp1)] && O_RDATA == 32'(idx_id($past(hp1))))
        else $error("ack did not activate");
    type_espi_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_RD && I_ADDR == A_TYPE) |=>
        O_RDATA[T_ESPI] == (HAS_ESPI && !$past(legacy)))
        else $error("extended range bit wrong");
    common_bp_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_RD && I_ADDR == A_BP1 && r.ctrl[C_CBPR]) |=>
        O_RDATA == 32'($past(r.bp0)))
        else $error("common point not used");
    ns_ack0_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_RD && I_ADDR == A_ACK0 && !ds && !I_SECURE) |=>
        O_RDATA == 32'(SPURIOUS) && r.act == $past(r.act))
        else $error("non-secure group 0 ack not refused");
    sgi_free_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_WR && I_ADDR == A_SGI && ds) |=>
        O_SGI_RAISE ##1 (O_SGI_RAISE == $past(I_WR && I_ADDR == A_SGI)))
        else $error("single state sgi not raised");
endmodule : sgp_shared_irq

// File: logic/sgp_pkg.sv
package sgp_pkg;
    // ******************************
    // sizes and identifier layout
    // ******************************
    localparam int NIRQ = 8; // shared interrupts held here
    localparam int NBASE = 4; // of them in the regular range
    localparam int IDX_W = 3; // index width
    localparam int ID_W = 13; // interrupt_identifier width
    localparam int BPR_W = 3; // binary point width
    localparam logic [ID_W-1:0] BASE_ID = 13'h0020; // first regular id
    localparam logic [ID_W-1:0] EXT_ID = 13'h1000; // extended range start
    localparam logic [ID_W-1:0] EXT_LAST = 13'h13ff; // extended range end
    localparam logic [ID_W-1:0] SPURIOUS = 13'h03ff; // nothing to give
    // ******************************
    // implementation choices
    // ******************************
    localparam logic HAS_ESPI = 1'h1; // extended range built
    localparam logic HAS_MBIS = 1'h1; // message writes built
    localparam logic LVL_PCLR_MSG = 1'h0; // pending clear hits msg level
    localparam logic LVL_MCLR_SW = 1'h0; // msg clear hits sw pending
    localparam logic ACK_CLR_SW = 1'h1; // ack clears sw pending
    // ******************************
    // register offsets
    // ******************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TYPE = 8'h04;
    localparam logic [7:0] A_SET_NS = 8'h08;
    localparam logic [7:0] A_SET_S = 8'h0c;
    localparam logic [7:0] A_CLR_NS = 8'h10;
    localparam logic [7:0] A_CLR_S = 8'h14;
    localparam logic [7:0] A_PSET = 8'h18;
    localparam logic [7:0] A_PCLR = 8'h1c;
    localparam logic [7:0] A_GRP = 8'h20;
    localparam logic [7:0] A_MOD = 8'h24;
    localparam logic [7:0] A_EDGE = 8'h28;
    localparam logic [7:0] A_ACT = 8'h2c;
    localparam logic [7:0] A_ACK0 = 8'h30;
    localparam logic [7:0] A_ACK1 = 8'h34;
    localparam logic [7:0] A_EOI0 = 8'h38;
    localparam logic [7:0] A_EOI1 = 8'h3c;
    localparam logic [7:0] A_BP0 = 8'h40;
    localparam logic [7:0] A_BP1 = 8'h44;
    localparam logic [7:0] A_HP0 = 8'h48;
    localparam logic [7:0] A_HP1 = 8'h4c;
    localparam logic [7:0] A_ROUTE = 8'h50;
    localparam logic [7:0] A_NSACR = 8'h54;
    localparam logic [7:0] A_SGI = 8'h58;
    // ******************************
    // control and type fields
    // ******************************
    localparam int CTRL_W = 10;
    localparam int C_DS = 0; // disable_security_bit
    localparam int C_LEGACY = 1; // legacy operation
    localparam int C_CBPR = 2; // common_binary_point_bit
    localparam int C_CBPR_NS = 3; // common_point_nonsecure_sel
    localparam int C_CBPR_S = 4; // common_point_secure_sel
    localparam int C_SRE = 5; // sysreg_interface_enable
    localparam int C_EL3 = 6; // highest_exception_level present
    localparam int C_EN0 = 7; // group0_enable
    localparam int C_EN1NS = 8; // group1_enable, non-secure
    localparam int C_EN1S = 9; // group1_enable, secure
    localparam int T_ESPI = 0; // extended_shared_range_present
    localparam int T_MBIS = 1; // message_shared_irq_present
    localparam int T_LPI = 2; // locality group code, two bits
    localparam int NSACR_G0 = 0; // non-secure may raise group 0
    localparam int NSACR_S1 = 1; // non-secure may raise secure group 1
    // ******************************
    // group codes
    // ******************************
    localparam logic [1:0] GRP_G0 = 2'h0;
    localparam logic [1:0] GRP_S1 = 2'h1;
    localparam logic [1:0] GRP_NS1 = 2'h2; // also plain group 1
    // ******************************
    // state
    // ******************************
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [NIRQ-1:0] edge_cfg, grp, modf, route, pend_sw, pend_msg, act;
        logic [NIRQ-1:0] s1, s2, s3, filt;
        logic [BPR_W-1:0] bp0, bp1ns, bp1s;
        logic [1:0] nsacr;
        logic [31:0] rdata;
        logic irq0, irq1, software_generated_irq;
        logic [1:0] sgi_grp;
    } sgp_state_t;
    localparam sgp_state_t SGP_STATE_RST = '0;
endpackage : sgp_pkg

// File: verif/sgp_pe_model.sv
`timescale 1ns/1ns
// ****************************************
// far side: peripheral lines and element
// ****************************************
module sgp_pe_model
    import sgp_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // wanted line levels from the scenario
    input wire logic [NIRQ-1:0] i_want,
    // element side inputs
    input wire logic i_sgi_raise,
    // wired lines and observed sgi count
    output logic [NIRQ-1:0] o_wired,
    output logic [7:0] o_sgi_cnt
);
    // lines move just after an edge; trigger mode never flips while pending
    always_ff @(posedge i_clk)
    begin
        o_wired <= i_rst ? '0 : i_want;
    end
    // one element accepts every group it is sent, no misrouting here
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_sgi_cnt <= 8'h00;
        else if (i_sgi_raise)
            o_sgi_cnt <= o_sgi_cnt + 8'h01;
    end
endmodule : sgp_pe_model

// File: verif/tb.sv
`timescale 1ns/1ns
// ****************************************
// bench for the shared interrupt block
// ****************************************
module tb;
    import sgp_pkg::*;
    logic clk, rst, wr, rd, sec, g0, g1, sraise;
    logic [7:0] addr, scnt;
    logic [31:0] wdata, rdata;
    logic [NIRQ-1:0] want, wired;
    logic [1:0] sgrp;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    sgp_shared_irq sgp_shared_irq_inst (.I_REF_CLK(clk), .I_RST(rst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .I_SECURE(sec), .O_RDATA(rdata), .I_WIRED_IRQ(wired),
        .O_IRQ_G0(g0), .O_IRQ_G1(g1), .O_SGI_RAISE(sraise), .O_SGI_GRP(sgrp));
    sgp_pe_model sgp_pe_model_inst (.i_clk(clk), .i_rst(rst), .i_want(want),
        .i_sgi_raise(sraise), .o_wired(wired), .o_sgi_cnt(scnt));
    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard, well above the roughly 165 cycles needed
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 2000)
        begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one write cycle; strobe dropped at the next edge
    task automatic w(input logic [7:0] a, input logic [31:0] d, input int s);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        sec <= s[0];
        @(posedge clk);
        wr <= 1'b0;
    endtask : w
    // one read cycle; data stands only in the following cycle
    task automatic r(input logic [7:0] a, input logic [31:0] e, input int s);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        sec <= s[0];
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, rdata);
    endtask : r
    task automatic tally_and_finish();
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        sec = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        want = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        r(A_TYPE, 32'h0000000b, 1);
        w(A_CTRL, 32'h000003e0, 1);
        w(A_CTRL, 32'h000003e1, 0);
        r(A_CTRL, 32'h000003e0, 1);
        // edge index 0 by secure message set
        w(A_EDGE, 32'h00000001, 1);
        w(A_SET_S, 32'h00000020, 1);
        r(A_PSET, 32'h00000001, 1);
        r(A_HP0, 32'h00000020, 1);
        r(A_ACK0, 32'h00000020, 1);
        r(A_PSET, 32'h00000000, 1);
        r(A_ACT, 32'h00000001, 1);
        w(A_EOI0, 32'h00000020, 1);
        r(A_ACT, 32'h00000000, 1);
        // level index 1: ack leaves it active and pending
        w(A_SET_S, 32'h00000021, 1);
        r(A_ACK0, 32'h00000021, 1);
        r(A_PSET, 32'h00000002, 1);
        r(A_ACT, 32'h00000002, 1);
        repeat (3) @(posedge clk);
        #1;
        chk("irq g0", 32'h0, {31'h0, g0});
        w(A_PCLR, 32'h00000002, 1);
        r(A_PSET, 32'h00000002, 1);
        w(A_CLR_S, 32'h00000021, 1);
        r(A_PSET, 32'h00000000, 1);
        w(A_EOI0, 32'h00000021, 1);
        // software pending on level index 3, dropped by its ack
        w(A_PSET, 32'h00000008, 1);
        r(A_ACK0, 32'h000003ff, 0);
        r(A_ACK0, 32'h00000023, 1);
        r(A_PSET, 32'h00000000, 1);
        w(A_EOI0, 32'h00000023, 1);
        // unknown ids, extended range, legacy
        w(A_SET_S, 32'h00000024, 1);
        w(A_SET_S, 32'h000013ff, 1);
        r(A_PSET, 32'h00000000, 1);
        w(A_SET_S, 32'h00001000, 1);
        r(A_PSET, 32'h00000010, 1);
        w(A_CLR_S, 32'h00001000, 1);
        w(A_CTRL, 32'h000003e2, 1);
        r(A_TYPE, 32'h0000000a, 1);
        w(A_SET_S, 32'h00001001, 1);
        r(A_PSET, 32'h00000000, 1);
        w(A_CTRL, 32'h000003e0, 1);
        // banked group 1 binary point, the common bit and the secure common select
        w(A_BP0, 32'h00000005, 1);
        w(A_BP1, 32'h00000003, 1);
        w(A_BP1, 32'h00000006, 0);
        r(A_BP1, 32'h00000003, 1);
        r(A_BP1, 32'h00000006, 0);
        w(A_CTRL, 32'h000003f0, 1);
        r(A_BP1, 32'h00000005, 1);
        r(A_BP1, 32'h00000006, 0);
        w(A_CTRL, 32'h000003e4, 1);
        r(A_BP1, 32'h00000005, 0);
        w(A_CTRL, 32'h000003e0, 1);
        // non-secure group 1 through the group 1 interface
        w(A_GRP, 32'h00000001, 1);
        w(A_SET_NS, 32'h00000020, 0);
        repeat (3) @(posedge clk);
        #1;
        chk("irq g1", 32'h1, {31'h0, g1});
        chk("irq g0 idle", 32'h0, {31'h0, g0});
        r(A_ACK1, 32'h00000020, 0);
        w(A_EOI1, 32'h00000020, 0);
        // secure group 1 seen as group 0 without top level
        w(A_GRP, 32'h00000000, 1);
        w(A_MOD, 32'h00000001, 1);
        w(A_CTRL, 32'h000003a0, 1);
        w(A_SET_S, 32'h00000020, 1);
        r(A_HP0, 32'h00000020, 1);
        r(A_ACK0, 32'h00000020, 1);
        w(A_EOI0, 32'h00000020, 1);
        // sgi permission
        w(A_NSACR, 32'h00000000, 1);
        w(A_SGI, 32'h00000000, 0);
        w(A_SGI, 32'h00000001, 1);
        repeat (2) @(posedge clk);
        #1;
        chk("sgi count", 32'h1, {24'h0, scnt});
        chk("sgi group", 32'h1, {30'h0, sgrp});
        w(A_NSACR, 32'h00000001, 1);
        w(A_SGI, 32'h00000000, 0);
        repeat (2) @(posedge clk);
        #1;
        chk("sgi count ns", 32'h2, {24'h0, scnt});
        w(A_CTRL, 32'h000003e1, 1);
        w(A_SGI, 32'h00000000, 0);
        repeat (2) @(posedge clk);
        #1;
        chk("sgi count ds", 32'h3, {24'h0, scnt});
        // wired level line on index 2
        want <= 8'h04;
        repeat (6) @(posedge clk);
        r(A_PSET, 32'h00000004, 1);
        chk("irq g0 wired", 32'h1, {31'h0, g0});
        want <= 8'h00;
        repeat (6) @(posedge clk);
        r(A_PSET, 32'h00000000, 1);
        tally_and_finish();
    end
endmodule : tb
